// ### verilog/frtcc_top.sv
// frtcc_top: 16-bit free-running timer, two compare outputs, four capture inputs
// assumes an apb master on pclk; pins are asynchronous and synchronised here
// auto-add and capture mask regs are storage only
//
// How it works
// R1 - 16-bit counter steps once per count pulse from the two-bit clock select
// R2 - counter may clear on compare match a instead of free running
// R3 - wrap from all ones to zero sets the wrap flag
// R4 - counter loads zero on reset and hardware standby
// R5 - both compare values watched continuously; equality sets the channel match flag
// R6 - on match with output enable set, pin takes the output level bit
// R7 - compare pins stay low after reset until their first match
// R8 - compare values become all ones on reset and standby
// R9 - selected capture edge copies counter into capture value, sets flag same cycle
// R10 - one edge select bit per capture channel picks rising or falling
// R11 - buffer enables make c buffer a, and d buffer b
// R12 - buffered: both 0 falling, both 1 rising, differing means both edges
// R13 - capture happens even while its flag is still set
// R14 - outside source keeps capture pulses 1.5 clocks wide, 2.5 for both edges
// R15 - all capture values clear to zero on reset and standby
// R16 - compare a and b share one address, picked by compare select bit
// R17 - captures a-c share addresses with step and mask regs, picked by capture select
// R18 - flag bits 7..1 clear only by writing 0; bit 0 plain read/write
// R19 - bit 0 of the flag register selects clear on match a
// R20 - each flag requests its interrupt only while flag and its enable are 1
// R21 - buffered capture moves old primary value to buffer before loading new
// R22 - capture pins synchronised, edges found from successive synchronised samples
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
module frtcc_top (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [frtcc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // chip level
  input wire logic hw_standby,
  output logic [6:0] irq_req,
  // timer pins
  input wire logic ext_count_clk_in,
  input wire logic capture_in_a,
  input wire logic capture_in_b,
  input wire logic capture_in_c,
  input wire logic capture_in_d,
  output logic compare_out_a,
  output logic compare_out_b
);
  // register file
  logic [7:0] module_stop_high;
  logic [7:0] module_stop_low;
  logic [7:1] irq_enable;
  logic [7:0] flag_status_ctrl;

  // counter and compare values
  logic [15:0] free_running_count;
  logic [15:0] compare_value_a;
  logic [15:0] compare_value_b;
  logic [7:0] edge_clock_ctrl;
  logic [7:0] compare_output_ctrl;

  // captures and their address partners
  logic [15:0] capture_value_a;
  logic [15:0] capture_value_b;
  logic [15:0] capture_value_c;
  logic [15:0] capture_value_d;
  logic [15:0] auto_add_step_r;
  logic [15:0] auto_add_step_f;
  logic [15:0] capture_mask_len;
  // synchronisers: stage 1 feeds stage 2 only, stage 3 holds the previous sample
  logic [5:0] sync1;
  logic [5:0] sync2;
  logic [4:0] sync3;
  // prescaler width follows the slowest tap
  localparam int PRE_BITS = frtcc_pkg::PRE_W;
  logic [PRE_BITS-1:0] prescale;

  // equality history for match events
  logic match_a_q;
  logic match_b_q;

  // pin order in the synchroniser: standby, ext clock, capture a..d
  logic [5:0] pins_raw;
  assign pins_raw = {hw_standby, ext_count_clk_in, capture_in_a, capture_in_b,
                     capture_in_c, capture_in_d};

  // standby lags its pin by two clocks
  wire standby = sync2[5];
  wire [3:0] cap_now = sync2[3:0];
  wire [3:0] cap_old = sync3[3:0];
  wire [3:0] cap_rise = cap_now & ~cap_old; // [R22]
  wire [3:0] cap_fall = ~cap_now & cap_old; // [R22]
  wire ext_rise = sync2[4] & ~sync3[4];

  // apb decode; registers answer with no wait state
  wire [15:0] idx = paddr[frtcc_pkg::ADDR_W-1:2];
  wire aligned = (paddr[1:0] == 2'b00);
  wire setup = psel & ~penable;
  // writes take effect at the access edge
  wire wr = psel & penable & pwrite & ~pslverr;

  // lanes 2 and 3 are ignored
  wire lane0 = pstrb[0];
  wire lane1 = pstrb[1];
  // select bits for the shared addresses
  wire sel_b = compare_output_ctrl[frtcc_pkg::OC_CMP_SEL];
  wire sel_step = compare_output_ctrl[frtcc_pkg::OC_CAP_SEL];

  // unaligned addresses hit nothing
  wire hit_stop_hi = aligned & (idx == frtcc_pkg::IDX_STOP_HI);
  wire hit_stop_lo = aligned & (idx == frtcc_pkg::IDX_STOP_LO);
  wire hit_irq = aligned & (idx == frtcc_pkg::IDX_IRQ_EN);
  wire hit_flags = aligned & (idx == frtcc_pkg::IDX_FLAGS);
  wire hit_count = aligned & (idx == frtcc_pkg::IDX_COUNT);
  wire hit_cmp = aligned & (idx == frtcc_pkg::IDX_COMPARE);
  wire hit_ec = aligned & (idx == frtcc_pkg::IDX_EDGE_CLK);
  wire hit_oc = aligned & (idx == frtcc_pkg::IDX_OUT_CTRL);
  wire hit_ca = aligned & (idx == frtcc_pkg::IDX_CAP_A);
  wire hit_cb = aligned & (idx == frtcc_pkg::IDX_CAP_B);
  wire hit_cc = aligned & (idx == frtcc_pkg::IDX_CAP_C);
  wire hit_cd = aligned & (idx == frtcc_pkg::IDX_CAP_D);
  wire hit_any = hit_stop_hi | hit_stop_lo | hit_irq | hit_flags | hit_count | hit_cmp |
                 hit_ec | hit_oc | hit_ca | hit_cb | hit_cc | hit_cd;

  // write strobes; shared addresses routed by the select bits
  wire wr_cmp_a = wr & hit_cmp & ~sel_b; // [R16]
  wire wr_cmp_b = wr & hit_cmp & sel_b; // [R16]
  wire wr_step_r = wr & hit_ca & sel_step; // [R17]
  wire wr_step_f = wr & hit_cb & sel_step; // [R17]
  wire wr_mask = wr & hit_cc & sel_step; // [R17]
  // counter and flag writes
  wire wr_count = wr & hit_count;
  wire wr_flags = wr & hit_flags & lane0;

  // read mux; capture values are read-only, writes to them fall away
  logic [15:0] rd_val;
  assign rd_val =
    hit_stop_hi ? {8'h00, module_stop_high} :
    hit_stop_lo ? {8'h00, module_stop_low} :
    hit_irq ? {8'h00, irq_enable, 1'b1} :
    hit_flags ? {8'h00, flag_status_ctrl} :
    hit_count ? free_running_count :
    hit_cmp ? (sel_b ? compare_value_b : compare_value_a) : // [R16]
    hit_ec ? {8'h00, edge_clock_ctrl} :
    hit_oc ? {8'h00, compare_output_ctrl} :
    hit_ca ? (sel_step ? auto_add_step_r : capture_value_a) : // [R17]
    hit_cb ? (sel_step ? auto_add_step_f : capture_value_b) : // [R17]
    hit_cc ? (sel_step ? capture_mask_len : capture_value_c) : // [R17]
    hit_cd ? capture_value_d : 16'h0000;

  // count pulse from the selected source
  logic tick;
  always_comb begin
    unique case (frtcc_pkg::frtcc_clk_e'(edge_clock_ctrl[frtcc_pkg::EC_CLK_HI:
                                                       frtcc_pkg::EC_CLK_LO]))
      frtcc_pkg::FRTCC_CLK_DIV2: tick = &prescale[frtcc_pkg::TAP_DIV2:0]; // [R1]
      frtcc_pkg::FRTCC_CLK_DIV8: tick = &prescale[frtcc_pkg::TAP_DIV8:0]; // [R1]
      frtcc_pkg::FRTCC_CLK_DIV32: tick = &prescale[frtcc_pkg::TAP_DIV32:0]; // [R1]
      frtcc_pkg::FRTCC_CLK_EXT: tick = ext_rise; // [R1]
    endcase
  end

  // compare and counter next values
  // events fire when equality begins
  wire match_a = (free_running_count == compare_value_a); // [R5]
  wire match_b = (free_running_count == compare_value_b); // [R5]
  wire match_a_ev = match_a & ~match_a_q;
  wire match_b_ev = match_b & ~match_b_q;
  wire clr_on_a = flag_status_ctrl[frtcc_pkg::FL_CLR_SEL]; // [R19]
  // no wrap when match a clears
  wire wrap = tick & ~(clr_on_a & match_a) & (free_running_count == frtcc_pkg::COUNT_MAX);

  logic [15:0] next_free_running_count;
  always_comb begin
    next_free_running_count = free_running_count;
    if (wr_count) begin
      // a software write takes priority over the count pulse
      if (lane1) next_free_running_count[15:8] = pwdata[15:8];
      if (lane0) next_free_running_count[7:0] = pwdata[7:0];
      // clear replaces the step
    end else if (tick & clr_on_a & match_a) begin
      next_free_running_count = frtcc_pkg::RST_COUNT; // [R2]
    end else if (tick) begin
      next_free_running_count = free_running_count + 16'h0001; // [R1]
    end
  end

  // capture triggers; buffered pairs use both edge bits of the pair
  wire [3:0] edge_sel = edge_clock_ctrl[frtcc_pkg::EC_EDGE_A:frtcc_pkg::EC_EDGE_D];
  wire buf_a = edge_clock_ctrl[frtcc_pkg::EC_BUF_A]; // [R11]
  wire buf_b = edge_clock_ctrl[frtcc_pkg::EC_BUF_B]; // [R11]
  wire [3:0] trig_plain = (edge_sel & cap_rise) | (~edge_sel & cap_fall); // [R10]
  wire trig_buf_a = (edge_sel[3] == edge_sel[1]) ? trig_plain[3] :
                    (cap_rise[3] | cap_fall[3]); // [R12]
  wire trig_buf_b = (edge_sel[2] == edge_sel[0]) ? trig_plain[2] :
                    (cap_rise[2] | cap_fall[2]); // [R12]

  // buffer mode picks the pair's trigger
  wire trig_a = buf_a ? trig_buf_a : trig_plain[3];
  wire trig_b = buf_b ? trig_buf_b : trig_plain[2];
  // in buffer mode the c and d pins no longer capture
  wire trig_c = ~buf_a & trig_plain[1];
  wire trig_d = ~buf_b & trig_plain[0];

  // flags: hardware set wins over a software clear in the same cycle
  logic [7:0] set_flags;
  logic [7:0] next_flags;
  assign set_flags = {trig_a, trig_b, trig_c, trig_d, match_a_ev, match_b_ev, wrap, 1'b0};
  always_comb begin
    next_flags = flag_status_ctrl;
    if (wr_flags) begin
      next_flags[7:1] = flag_status_ctrl[7:1] & pwdata[7:1]; // [R18]
      next_flags[frtcc_pkg::FL_CLR_SEL] = pwdata[frtcc_pkg::FL_CLR_SEL]; // [R18]
    end
    // a set in the clearing cycle wins
    next_flags = next_flags | set_flags; // [R3] [R5] [R9]
  end

  // interrupt requests follow flag and enable
  // requests are plain levels
  assign irq_req = flag_status_ctrl[7:1] & irq_enable[7:1]; // [R20]

  // apb answer: response latched in the setup cycle, zero wait states
  assign pready = 1'b1;

  // pin synchronisers and edge history
  // pins assumed idle low after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 6'h00;
      sync2 <= 6'h00;
      sync3 <= 5'h00;
    end else begin
      sync1 <= pins_raw;
      sync2 <= sync1; // [R22]
      sync3 <= sync2[4:0];
    end
  end

  // apb response registers
  // capture value writes drop silently
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= {16'h0000, rd_val};
      pslverr <= ~hit_any;
    end
  end

  // prescaler, counter and match history
  // standby restarts the prescaler
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale <= '0;
      free_running_count <= frtcc_pkg::RST_COUNT; // [R4]
      match_a_q <= 1'b0;
      match_b_q <= 1'b0;
    end else if (standby) begin
      prescale <= '0;
      free_running_count <= frtcc_pkg::RST_COUNT; // [R4]
      match_a_q <= 1'b0;
      match_b_q <= 1'b0;
    end else begin
      prescale <= prescale + {{(PRE_BITS-1){1'b0}}, 1'b1};
      free_running_count <= next_free_running_count;
      match_a_q <= match_a;
      match_b_q <= match_b;
    end
  end

  // control registers and flags
  // module stop bits survive standby
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      module_stop_high <= frtcc_pkg::RST_STOP_HI;
      module_stop_low <= frtcc_pkg::RST_STOP_LO;
      irq_enable <= frtcc_pkg::RST_IRQ_EN[7:1];
      flag_status_ctrl <= frtcc_pkg::RST_FLAGS;
      edge_clock_ctrl <= frtcc_pkg::RST_CTRL;
      compare_output_ctrl <= frtcc_pkg::RST_CTRL;
    end else if (standby) begin
      irq_enable <= frtcc_pkg::RST_IRQ_EN[7:1];
      flag_status_ctrl <= frtcc_pkg::RST_FLAGS;
      edge_clock_ctrl <= frtcc_pkg::RST_CTRL;
      compare_output_ctrl <= frtcc_pkg::RST_CTRL;
    end else begin
      if (wr & hit_stop_hi & lane0) module_stop_high <= pwdata[7:0];
      if (wr & hit_stop_lo & lane0) module_stop_low <= pwdata[7:0];
      if (wr & hit_irq & lane0) irq_enable <= pwdata[7:1];
      if (wr & hit_ec & lane0) edge_clock_ctrl <= pwdata[7:0];
      if (wr & hit_oc & lane0) compare_output_ctrl <= pwdata[7:0];
      flag_status_ctrl <= next_flags; // [R13]
    end
  end

  // compare and step registers; byte lanes honoured on compare and step, mask takes lane 0 only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_value_a <= frtcc_pkg::RST_COMPARE; // [R8]
      compare_value_b <= frtcc_pkg::RST_COMPARE; // [R8]
      auto_add_step_r <= frtcc_pkg::RST_STEP;
      auto_add_step_f <= frtcc_pkg::RST_STEP;
      capture_mask_len <= frtcc_pkg::RST_MASK;
    end else if (standby) begin
      compare_value_a <= frtcc_pkg::RST_COMPARE; // [R8]
      compare_value_b <= frtcc_pkg::RST_COMPARE; // [R8]
      auto_add_step_r <= frtcc_pkg::RST_STEP;
      auto_add_step_f <= frtcc_pkg::RST_STEP;
      capture_mask_len <= frtcc_pkg::RST_MASK;
    end else begin
      if (wr_cmp_a & lane1) compare_value_a[15:8] <= pwdata[15:8];
      if (wr_cmp_a & lane0) compare_value_a[7:0] <= pwdata[7:0];
      if (wr_cmp_b & lane1) compare_value_b[15:8] <= pwdata[15:8];
      if (wr_cmp_b & lane0) compare_value_b[7:0] <= pwdata[7:0];
      if (wr_step_r & lane1) auto_add_step_r[15:8] <= pwdata[15:8];
      if (wr_step_r & lane0) auto_add_step_r[7:0] <= pwdata[7:0];
      if (wr_step_f & lane1) auto_add_step_f[15:8] <= pwdata[15:8];
      if (wr_step_f & lane0) auto_add_step_f[7:0] <= pwdata[7:0];
      // upper byte of the mask length is fixed at zero
      if (wr_mask & lane0) capture_mask_len[7:0] <= pwdata[7:0];
    end
  end

  // capture registers; the flag state never blocks a transfer
  // buffer and primary load in one edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_value_a <= frtcc_pkg::RST_CAPTURE; // [R15]
      capture_value_b <= frtcc_pkg::RST_CAPTURE; // [R15]
      capture_value_c <= frtcc_pkg::RST_CAPTURE; // [R15]
      capture_value_d <= frtcc_pkg::RST_CAPTURE; // [R15]
    end else if (standby) begin
      capture_value_a <= frtcc_pkg::RST_CAPTURE; // [R15]
      capture_value_b <= frtcc_pkg::RST_CAPTURE; // [R15]
      capture_value_c <= frtcc_pkg::RST_CAPTURE; // [R15]
      capture_value_d <= frtcc_pkg::RST_CAPTURE; // [R15]
    end else begin
      if (trig_a) capture_value_a <= free_running_count; // [R9] [R13]
      if (trig_b) capture_value_b <= free_running_count; // [R9] [R13]
      if (trig_a & buf_a) capture_value_c <= capture_value_a; // [R21]
      else if (trig_c) capture_value_c <= free_running_count; // [R9]
      if (trig_b & buf_b) capture_value_d <= capture_value_b; // [R21]
      else if (trig_d) capture_value_d <= free_running_count; // [R9]
    end
  end

  // compare output pins: low until the first enabled match
  // level holds between matches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_out_a <= 1'b0; // [R7]
      compare_out_b <= 1'b0; // [R7]
    end else if (standby) begin
      compare_out_a <= 1'b0; // [R7]
      compare_out_b <= 1'b0; // [R7]
    end else begin
      if (match_a_ev & compare_output_ctrl[frtcc_pkg::OC_OE_A])
        compare_out_a <= compare_output_ctrl[frtcc_pkg::OC_LVL_A]; // [R6]
      if (match_b_ev & compare_output_ctrl[frtcc_pkg::OC_OE_B])
        compare_out_b <= compare_output_ctrl[frtcc_pkg::OC_LVL_B]; // [R6]
    end
  end

endmodule // frtcc_top

// ### verilog/frtcc_pkg.sv
// frtcc_pkg: constants for the free-running timer with capture and compare
// assumes apb addressing where each register index sits at byte address index*4
package frtcc_pkg;
  // apb byte address width: highest index 16'hFF9E times four needs 18 bits
  localparam int ADDR_W = 18;
  // register indices as printed; byte address is index*4
  localparam logic [15:0] IDX_STOP_HI = 16'hFF86;
  localparam logic [15:0] IDX_STOP_LO = 16'hFF87;
  localparam logic [15:0] IDX_IRQ_EN = 16'hFF90;
  localparam logic [15:0] IDX_FLAGS = 16'hFF91;
  localparam logic [15:0] IDX_COUNT = 16'hFF92;
  localparam logic [15:0] IDX_COMPARE = 16'hFF94;
  localparam logic [15:0] IDX_EDGE_CLK = 16'hFF96;
  localparam logic [15:0] IDX_OUT_CTRL = 16'hFF97;
  localparam logic [15:0] IDX_CAP_A = 16'hFF98;
  localparam logic [15:0] IDX_CAP_B = 16'hFF9A;
  localparam logic [15:0] IDX_CAP_C = 16'hFF9C;
  localparam logic [15:0] IDX_CAP_D = 16'hFF9E;
  // values after reset; all but the module stop bytes also load on standby
  localparam logic [7:0] RST_STOP_HI = 8'h3F;
  localparam logic [7:0] RST_STOP_LO = 8'hFF;
  localparam logic [7:0] RST_IRQ_EN = 8'h01;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [15:0] RST_COMPARE = 16'hFFFF;
  localparam logic [15:0] RST_CAPTURE = 16'h0000;
  localparam logic [15:0] RST_STEP = 16'hFFFF;
  localparam logic [15:0] RST_MASK = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  // flag_status_ctrl bit positions
  localparam int FL_CAP_A = 7;
  localparam int FL_CAP_B = 6;
  localparam int FL_CAP_C = 5;
  localparam int FL_CAP_D = 4;
  localparam int FL_MATCH_A = 3;
  localparam int FL_MATCH_B = 2;
  localparam int FL_WRAP = 1;
  localparam int FL_CLR_SEL = 0;
  // edge_clock_ctrl bit positions
  localparam int EC_EDGE_A = 7;
  localparam int EC_EDGE_B = 6;
  localparam int EC_EDGE_C = 5;
  localparam int EC_EDGE_D = 4;
  localparam int EC_BUF_A = 3;
  localparam int EC_BUF_B = 2;
  localparam int EC_CLK_HI = 1;
  localparam int EC_CLK_LO = 0;
  // compare_output_ctrl bit positions
  localparam int OC_CAP_SEL = 5;
  localparam int OC_CMP_SEL = 4;
  localparam int OC_OE_A = 3;
  localparam int OC_OE_B = 2;
  localparam int OC_LVL_A = 1;
  localparam int OC_LVL_B = 0;
  // clock source select codes and prescaler taps
  typedef enum logic [1:0] {
    FRTCC_CLK_DIV2 = 2'b00,
    FRTCC_CLK_DIV8 = 2'b01,
    FRTCC_CLK_DIV32 = 2'b10,
    FRTCC_CLK_EXT = 2'b11
  } frtcc_clk_e;
  localparam int PRE_W = 5;
  localparam int TAP_DIV2 = 0;
  localparam int TAP_DIV8 = 2;
  localparam int TAP_DIV32 = 4;
endpackage

// ### verif/frtcc_checker.sv
// frtcc_checker: port-level assertions for the capture/compare timer
// assumes it is bound into frtcc_top and sees only that module's ports
`timescale 1ns/1ps
module frtcc_checker (
  // apb side
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [frtcc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // chip level and pins
  input wire logic hw_standby,
  input wire logic [6:0] irq_req,
  input wire logic compare_out_a,
  input wire logic compare_out_b
);
  logic [3:0] sb_hist;
  wire acc = psel && penable;
  wire sb_seen = (|sb_hist) || hw_standby;
  // standby history: the pin synchroniser delays its clearing effect by a few clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sb_hist <= 4'h0;
    else sb_hist <= {sb_hist[2:0], hw_standby};
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  mapped_ready_a:
    assert property (acc && paddr == {frtcc_pkg::IDX_COMPARE, 2'b00} |-> pready && !pslverr)
      else $error("compare access refused");
  upper_zero_a:
    assert property (acc |-> prdata[31:16] == 16'h0000) else $error("upper read bits set");
  err_data_a:
    assert property (acc && pslverr |-> prdata == 32'h0) else $error("data with error");
  misalign_err_a:
    assert property (acc && paddr[1:0] != 2'h0 |-> pslverr) else $error("no error");
  read_hold_a:
    assert property (acc |=> $stable(prdata)) else $error("read data moved");
  flag_clear_a:
    assert property (|($past(irq_req) & ~irq_req) |-> $past(acc && pwrite) || sb_seen)
      else $error("request dropped without write");
  standby_clear_a:
    assert property (hw_standby [*5] |-> irq_req == 7'h00 && !compare_out_a && !compare_out_b)
      else $error("standby left state");
  reset_low_a:
    assert property ($rose(presetn) |-> (!compare_out_a && !compare_out_b) [*2])
      else $error("compare pin high after reset");
endmodule // frtcc_checker

bind frtcc_top frtcc_checker chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .hw_standby(hw_standby), .irq_req(irq_req), .compare_out_a(compare_out_a),
  .compare_out_b(compare_out_b)
);

// ### verif/frtcc_pin_model.sv
// frtcc_pin_model: far side of the timer pins, capture inputs and count clock
// assumes the bench calls its tasks one at a time, on the timer clock
`timescale 1ns/1ps
module frtcc_pin_model (
  // timer clock
  input wire logic pclk,
  // pins towards the timer
  output logic ext_count_clk_in,
  output logic [3:0] cap_pins
);
  initial begin
    ext_count_clk_in = 1'b0;
    cap_pins = 4'h0;
  end
  // level change, then held five clocks: above both minimum pulse widths
  task automatic set_pin(input int ch, input logic v);
    @(posedge pclk);
    cap_pins[ch] <= v;
    repeat (5) @(posedge pclk);
  endtask
  // count clock bursts; the line rests low between bursts
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge pclk);
      ext_count_clk_in <= 1'b1;
      repeat (4) @(posedge pclk);
      ext_count_clk_in <= 1'b0;
      repeat (4) @(posedge pclk);
    end
    repeat (3) @(posedge pclk);
  endtask
endmodule // frtcc_pin_model

// ### verif/testbench.sv
// testbench: self-checking bench for frtcc_top with a reference counter model
// assumes frtcc_pin_model drives the pins and the checker is bound in
`timescale 1ns/1ps
module testbench;
  logic pclk, presetn, psel, penable, pwrite, hw_standby, pready, pslverr, er;
  logic [frtcc_pkg::ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [3:0] pstrb, pins, es;
  logic ext_clk, compare_out_a, compare_out_b;
  logic [6:0] irq_req;
  logic [15:0] c;
  int err_count = 0;
  int n_tests = 0;
  int m_cnt, m_cmp, m_cmpb, m_fl, i;
  logic [15:0] ri [9] = '{frtcc_pkg::IDX_STOP_HI, frtcc_pkg::IDX_STOP_LO,
    frtcc_pkg::IDX_IRQ_EN, frtcc_pkg::IDX_FLAGS, frtcc_pkg::IDX_COMPARE,
    frtcc_pkg::IDX_EDGE_CLK, frtcc_pkg::IDX_OUT_CTRL, frtcc_pkg::IDX_CAP_A,
    frtcc_pkg::IDX_CAP_D};
  logic [15:0] rv [9] = '{16'h3F, 16'hFF, 16'h01, 16'h00, 16'hFFFF, 16'h00, 16'h00,
    16'h0000, 16'h0000};
  frtcc_top uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hw_standby(hw_standby), .irq_req(irq_req),
    .ext_count_clk_in(ext_clk), .capture_in_a(pins[3]), .capture_in_b(pins[2]),
    .capture_in_c(pins[1]), .capture_in_d(pins[0]), .compare_out_a(compare_out_a),
    .compare_out_b(compare_out_b)
  );
  frtcc_pin_model pm (.pclk(pclk), .ext_count_clk_in(ext_clk), .cap_pins(pins));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; the request holds until pready is seen high
  task automatic apb(input logic [17:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    apb({idx, 2'b00}, 1'b1, d);
  endtask
  task automatic rdc(input logic [15:0] idx, input logic [31:0] exp);
    apb({idx, 2'b00}, 1'b0, 32'h0);
    chk(rd, exp);
  endtask
  // reference counter: one step per external tick, flags gathered in m_fl
  task automatic step(input int n, input bit clr);
    repeat (n) begin
      if (clr && m_cnt == m_cmp) m_cnt = 0;
      else begin
        if (m_cnt == 65535) m_fl |= 2;
        m_cnt = (m_cnt + 1) % 65536;
      end
      if (m_cnt == m_cmp) m_fl |= 8;
      if (m_cnt == m_cmpb) m_fl |= 4;
    end
    pm.ticks(n);
  endtask
  task automatic finish_test;
    $display("mismatches %0d of %0d checks", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // watchdog: the whole sequence needs well under ten thousand clocks
  initial begin
    repeat (30000) @(posedge pclk);
    err_count++;
    finish_test();
  end
  initial begin
    {presetn, psel, penable, pwrite, hw_standby} = 5'h00;
    paddr = '0;
    pwdata = 32'h0;
    pstrb = 4'hF;
    seed = 32'h9389;
    m_cmpb = 65535;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk({compare_out_a, compare_out_b}, 0);
    for (i = 0; i < 9; i++) rdc(ri[i], rv[i]);
    apb({frtcc_pkg::IDX_FLAGS, 2'b01}, 1'b0, 32'h0);
    chk(er, 1);
    // external count clock makes every count step deterministic
    wr(frtcc_pkg::IDX_EDGE_CLK, 32'h03);
    wr(frtcc_pkg::IDX_OUT_CTRL, 32'h0A);
    wr(frtcc_pkg::IDX_COMPARE, 32'h3);
    m_cmp = 3;
    wr(frtcc_pkg::IDX_COUNT, 32'h0);
    wr(frtcc_pkg::IDX_FLAGS, 32'h0);
    {m_cnt, m_fl} = 0;
    step(3, 0);
    rdc(frtcc_pkg::IDX_COUNT, m_cnt);
    chk({compare_out_a, compare_out_b}, 2'b10);
    rdc(frtcc_pkg::IDX_FLAGS, m_fl);
    wr(frtcc_pkg::IDX_IRQ_EN, 32'h08);
    @(negedge pclk);
    chk(irq_req, 7'h04);
    wr(frtcc_pkg::IDX_FLAGS, 32'h0);
    m_fl = 0;
    @(negedge pclk);
    chk(irq_req, 7'h00);
    wr(frtcc_pkg::IDX_FLAGS, 32'hFF);
    m_fl = 1;
    rdc(frtcc_pkg::IDX_FLAGS, m_fl);
    wr(frtcc_pkg::IDX_COUNT, 32'h0);
    m_cnt = 0;
    step(5, 1);
    rdc(frtcc_pkg::IDX_COUNT, m_cnt);
    rdc(frtcc_pkg::IDX_FLAGS, m_fl);
    wr(frtcc_pkg::IDX_FLAGS, 32'h0);
    wr(frtcc_pkg::IDX_COUNT, 32'hFFFE);
    {m_fl, m_cnt} = {32'd0, 32'd65534};
    step(3, 0);
    rdc(frtcc_pkg::IDX_COUNT, m_cnt);
    rdc(frtcc_pkg::IDX_FLAGS, m_fl);
    wr(frtcc_pkg::IDX_OUT_CTRL, 32'h1A);
    wr(frtcc_pkg::IDX_COMPARE, 32'h2);
    m_cmpb = 2;
    wr(frtcc_pkg::IDX_OUT_CTRL, 32'h0A);
    rdc(frtcc_pkg::IDX_COMPARE, 32'h3);
    wr(frtcc_pkg::IDX_OUT_CTRL, 32'h1F);
    rdc(frtcc_pkg::IDX_COMPARE, 32'h2);
    wr(frtcc_pkg::IDX_FLAGS, 32'h0);
    wr(frtcc_pkg::IDX_COUNT, 32'h1);
    {m_fl, m_cnt} = {32'd0, 32'd1};
    step(1, 0);
    chk(compare_out_b, 1);
    rdc(frtcc_pkg::IDX_FLAGS, m_fl);
    wr(frtcc_pkg::IDX_OUT_CTRL, 32'h20);
    rdc(frtcc_pkg::IDX_CAP_C, 32'h0);
    wr(frtcc_pkg::IDX_CAP_A, 32'hAA);
    rdc(frtcc_pkg::IDX_CAP_A, 32'hAA);
    wr(frtcc_pkg::IDX_OUT_CTRL, 32'h0A);
    wr(frtcc_pkg::IDX_CAP_A, 32'h1234);
    rdc(frtcc_pkg::IDX_CAP_A, 32'h0);
    // random edges and counts; the second pass finds every capture flag still set
    for (i = 0; i < 8; i++) begin
      seed = xs(seed);
      c = seed[15:0];
      es = seed[19:16];
      wr(frtcc_pkg::IDX_EDGE_CLK, {24'h0, es, 4'h3});
      wr(frtcc_pkg::IDX_COUNT, c);
      m_cnt = c;
      pm.set_pin(3 - i % 4, 1'b1);
      step(1, 0);
      pm.set_pin(3 - i % 4, 1'b0);
      rdc(frtcc_pkg::IDX_CAP_A + 16'(2 * (i % 4)), es[3 - i % 4] ? c : 16'(m_cnt));
    end
    wr(frtcc_pkg::IDX_IRQ_EN, 32'h80);
    @(negedge pclk);
    chk(irq_req, 7'h40);
    // buffered a: differing edge bits capture both edges, pin c ignored
    wr(frtcc_pkg::IDX_EDGE_CLK, 32'h8B);
    wr(frtcc_pkg::IDX_COUNT, 32'h40);
    m_cnt = 64;
    pm.set_pin(3, 1'b1);
    step(1, 0);
    pm.set_pin(3, 1'b0);
    pm.set_pin(1, 1'b1);
    pm.set_pin(1, 1'b0);
    rdc(frtcc_pkg::IDX_CAP_A, m_cnt);
    rdc(frtcc_pkg::IDX_CAP_C, 32'h40);
    wr(frtcc_pkg::IDX_STOP_HI, 32'h12);
    @(posedge pclk);
    hw_standby <= 1'b1;
    repeat (6) @(posedge pclk);
    hw_standby <= 1'b0;
    repeat (4) @(posedge pclk);
    apb({frtcc_pkg::IDX_COUNT, 2'b00}, 1'b0, 32'h0);
    chk(rd < 32'd16, 1);
    rdc(frtcc_pkg::IDX_COMPARE, 32'hFFFF);
    rdc(frtcc_pkg::IDX_CAP_A, 32'h0);
    wr(frtcc_pkg::IDX_EDGE_CLK, 32'h02);
    wr(frtcc_pkg::IDX_COUNT, 32'h0);
    repeat (64) @(posedge pclk);
    apb({frtcc_pkg::IDX_COUNT, 2'b00}, 1'b0, 32'h0);
    chk(rd - 2 < 2, 1);
    rdc(frtcc_pkg::IDX_STOP_HI, 32'h12);
    finish_test();
  end
endmodule // testbench
